/* logic/move_ctrl_pkg.sv */
// types and constants shared by the data-move / control-op sequencer
// assumes a single 50 MHz clock and one asynchronous active-high reset
package move_ctrl_pkg;

  // widths of the datapath
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned PTR_W        = 16;
  localparam int unsigned GPR_IDX_W    = 5;
  localparam int unsigned DISP_W       = 6;
  localparam int unsigned CODE_ADDR_W  = 15;
  localparam int unsigned CODE_DATA_W  = 16;

  // register an operand-less code fetch targets
  localparam logic [4:0] LOW_WORD_GPR_IDX = 5'h00;

  // reset values
  localparam logic [15:0] PTR_RESET  = 16'h0000;
  localparam logic [7:0]  BYTE_RESET = 8'h00;

  // cycles each operation occupies the sequencer, issue cycle included
  localparam int unsigned STORE_CYCLES      = 2;
  localparam int unsigned CODE_FETCH_CYCLES = 3;
  localparam int unsigned CODE_WRITE_CYCLES = 2;
  localparam int unsigned STACK_CYCLES      = 2;
  localparam int unsigned CONTROL_CYCLES    = 1;

  // operations the sequencer accepts
  typedef enum logic [3:0] {
    op_none,
    indirect_write_op,
    offset_write_op,
    direct_write_op,
    code_fetch_op,
    code_write_op,
    stack_save_op,
    stack_restore_op,
    doze_op,
    watchdog_kick_op,
    debug_halt_op
  } op_t;

  // pointer pair selection
  typedef enum logic [1:0] {
    ptr_x,
    ptr_y,
    ptr_z
  } ptr_sel_t;

  // pointer adjustment around an indirect access
  typedef enum logic [1:0] {
    adj_none,
    adj_post_inc,
    adj_pre_dec
  } adj_t;

  // sequencer states
  typedef enum logic [2:0] {
    st_idle,
    st_store,
    st_fetch,
    st_fetch_wb,
    st_code_write,
    st_stack,
    st_halted
  } exec_state_t;

endpackage : move_ctrl_pkg

/* logic/pointer_pairs.sv */
// three 16-bit pointer pairs with load and increment/decrement
// assumes updates arrive as one-cycle strobes on the core clock
`timescale 1ns/1ps
module pointer_pairs #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset,
  // software-side load of a whole pair
  input  wire logic                      load_en,
  input  wire move_ctrl_pkg::ptr_sel_t   load_sel,
  input  wire logic [WIDTH-1:0]          load_value,
  // adjustment from the sequencer
  input  wire logic                      adjust_en,
  input  wire move_ctrl_pkg::ptr_sel_t   adjust_sel,
  input  wire logic                      adjust_dec,
  // current pair values
  output logic [WIDTH-1:0]               ptr_x_value,
  output logic [WIDTH-1:0]               ptr_y_value,
  output logic [WIDTH-1:0]               ptr_z_value
);
  import move_ctrl_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] x;
    logic [WIDTH-1:0] y;
    logic [WIDTH-1:0] z;
  } pairs_t;

  pairs_t pairs_reg;
  pairs_t pairs_next;

  // full-width step, carry crosses into the high byte
  function automatic logic [WIDTH-1:0] step(input logic [WIDTH-1:0] v, input logic dec);
    step = dec ? WIDTH'(v - 1'b1) : WIDTH'(v + 1'b1);
  endfunction : step

  // adjust wins over a same-cycle load of that pair
  always_comb begin
    pairs_next = pairs_reg;
    if (load_en) begin
      case (load_sel)
        ptr_x:   pairs_next.x = load_value;
        ptr_y:   pairs_next.y = load_value;
        ptr_z:   pairs_next.z = load_value;
        default: pairs_next.x = pairs_reg.x;
      endcase
    end
    if (adjust_en) begin
      case (adjust_sel)
        ptr_x:   pairs_next.x = step(pairs_reg.x, adjust_dec);
        ptr_y:   pairs_next.y = step(pairs_reg.y, adjust_dec);
        ptr_z:   pairs_next.z = step(pairs_reg.z, adjust_dec);
        default: pairs_next.x = pairs_reg.x;
      endcase
    end
  end

  // pair storage
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pairs_reg <= '0;
    end else begin
      pairs_reg <= pairs_next;
    end
  end

  assign ptr_x_value = pairs_reg.x;
  assign ptr_y_value = pairs_reg.y;
  assign ptr_z_value = pairs_reg.z;

endmodule : pointer_pairs

/* logic/move_ctrl_seq.sv */
// sequencer for stores, code-memory access, stack and control operations
// assumes decode upstream, same-cycle reads from code memory and the stack
//
// Behaviour
// - plain indirect store, pointer kept, 2 cycles
// - store then pointer plus one, 2 cycles
// - pointer minus one then store, 2 cycles
// - store at second or third pointer plus displacement, 2 cycles
// - store at address from instruction, 2 cycles
// - code byte to register, optional increment, 3 cycles
// - write high:low register word to code
// - save register on stack, 2 cycles
// - restore register from stack, 2 cycles
// - doze, 1 cycle, to power management
// - watchdog kick, 1 cycle, restarts watchdog
// - debug halt, debug only, no flags
`timescale 1ns/1ps
module move_ctrl_seq (
  // clock and reset
  input  wire logic                                      clock,
  input  wire logic                                      reset,
  // issue port from the decoder
  input  wire logic                                      issue_valid,
  output logic                                           issue_ready,
  input  wire move_ctrl_pkg::op_t                        issue_op,
  input  wire move_ctrl_pkg::ptr_sel_t                   issue_ptr,
  input  wire move_ctrl_pkg::adj_t                       issue_adj,
  input  wire logic [move_ctrl_pkg::DISP_W-1:0]          issue_disp,
  input  wire logic [move_ctrl_pkg::PTR_W-1:0]           issue_direct_addr,
  input  wire logic [move_ctrl_pkg::GPR_IDX_W-1:0]       issue_gpr_idx,
  input  wire logic                                      issue_use_low_word,
  input  wire logic [move_ctrl_pkg::DATA_W-1:0]          source_gpr,
  input  wire logic [move_ctrl_pkg::DATA_W-1:0]          low_word_gpr,
  input  wire logic [move_ctrl_pkg::DATA_W-1:0]          high_word_gpr,
  // pointer pair load
  input  wire logic                                      ptr_load_en,
  input  wire move_ctrl_pkg::ptr_sel_t                   ptr_load_sel,
  input  wire logic [move_ctrl_pkg::PTR_W-1:0]           ptr_load_value,
  output logic [move_ctrl_pkg::PTR_W-1:0]                ptr_x_value,
  output logic [move_ctrl_pkg::PTR_W-1:0]                ptr_y_value,
  output logic [move_ctrl_pkg::PTR_W-1:0]                ptr_z_value,
  // data memory write port
  output logic                                           dmem_we,
  output logic [move_ctrl_pkg::PTR_W-1:0]                dmem_addr,
  output logic [move_ctrl_pkg::DATA_W-1:0]               dmem_wdata,
  // code memory port
  output logic                                           pmem_rd_en,
  output logic                                           pmem_we,
  output logic [move_ctrl_pkg::CODE_ADDR_W-1:0]          pmem_addr,
  output logic [move_ctrl_pkg::CODE_DATA_W-1:0]          pmem_wdata,
  input  wire logic [move_ctrl_pkg::CODE_DATA_W-1:0]     pmem_rdata,
  // stack port
  output logic                                           stack_push,
  output logic [move_ctrl_pkg::DATA_W-1:0]               stack_wdata,
  output logic                                           stack_pop,
  input  wire logic [move_ctrl_pkg::DATA_W-1:0]          stack_rdata,
  // register file write port
  output logic                                           gpr_we,
  output logic [move_ctrl_pkg::GPR_IDX_W-1:0]            gpr_widx,
  output logic [move_ctrl_pkg::DATA_W-1:0]               gpr_wdata,
  // status flags write strobe, never raised by these operations
  output logic                                           flags_we,
  // system control
  output logic                                           sleep_req,
  output logic                                           watchdog_restart,
  output logic                                           debug_halt,
  input  wire logic                                      debug_resume
);
  import move_ctrl_pkg::*;

  typedef struct packed {
    exec_state_t                state;
    logic                       dmem_we;
    logic [PTR_W-1:0]           dmem_addr;
    logic [DATA_W-1:0]          dmem_wdata;
    logic                       pmem_rd_en;
    logic                       pmem_we;
    logic [CODE_ADDR_W-1:0]     pmem_addr;
    logic                       pmem_hi_byte;
    logic [CODE_DATA_W-1:0]     pmem_wdata;
    logic                       stack_push;
    logic [DATA_W-1:0]          stack_wdata;
    logic                       gpr_we;
    logic [GPR_IDX_W-1:0]       gpr_widx;
    logic [DATA_W-1:0]          gpr_wdata;
    logic                       flags_we;
    logic                       sleep_req;
    logic                       watchdog_restart;
    logic                       debug_halt;
  } seq_t;

  seq_t seq_reg;
  seq_t seq_next;

  logic                 accept;
  logic                 adjust_en;
  logic                 adjust_dec;
  ptr_sel_t             adjust_sel;
  logic [PTR_W-1:0]     sel_ptr;

  // picks the current value of a pointer pair
  function automatic logic [PTR_W-1:0] pick_ptr(input ptr_sel_t sel, input logic [PTR_W-1:0] x,
                                                input logic [PTR_W-1:0] y, input logic [PTR_W-1:0] z);
    case (sel)
      ptr_x:   pick_ptr = x;
      ptr_y:   pick_ptr = y;
      default: pick_ptr = z;
    endcase
  endfunction : pick_ptr

  // pointer pair storage
  pointer_pairs #(
    .WIDTH       (PTR_W)
  ) u_pairs (
    .clock       (clock),
    .reset       (reset),
    .load_en     (ptr_load_en),
    .load_sel    (ptr_load_sel),
    .load_value  (ptr_load_value),
    .adjust_en   (adjust_en),
    .adjust_sel  (adjust_sel),
    .adjust_dec  (adjust_dec),
    .ptr_x_value (ptr_x_value),
    .ptr_y_value (ptr_y_value),
    .ptr_z_value (ptr_z_value)
  );

  // new work only from idle; halted waits for the debugger
  assign issue_ready = (seq_reg.state == st_idle);
  assign accept      = issue_valid && issue_ready;
  assign sel_ptr     = pick_ptr(issue_ptr, ptr_x_value, ptr_y_value, ptr_z_value);

  // pop in issue cycle, data lands next edge
  assign stack_pop = accept && (issue_op == stack_restore_op);

  // pointer adjustment happens on the accepting edge
  always_comb begin
    adjust_en  = 1'b0;
    adjust_dec = 1'b0;
    adjust_sel = issue_ptr;
    if (accept) begin
      case (issue_op)
        indirect_write_op: begin
          adjust_en  = (issue_adj != adj_none);
          adjust_dec = (issue_adj == adj_pre_dec);
        end
        code_fetch_op: begin
          // optional increment of the third pair
          adjust_en  = (issue_adj == adj_post_inc);
          adjust_sel = ptr_z;
        end
        default: adjust_en = 1'b0;
      endcase
    end
  end

  // next state and registered outputs
  always_comb begin
    seq_next = seq_reg;
    // strobes last one cycle unless set again
    seq_next.dmem_we          = 1'b0;
    seq_next.pmem_rd_en       = 1'b0;
    seq_next.pmem_we          = 1'b0;
    seq_next.stack_push       = 1'b0;
    seq_next.gpr_we           = 1'b0;
    seq_next.sleep_req        = 1'b0;
    seq_next.watchdog_restart = 1'b0;
    seq_next.debug_halt       = 1'b0;
    // these operations never touch the flags
    seq_next.flags_we         = 1'b0;
    case (seq_reg.state)
      st_idle: begin
        if (accept) begin
          case (issue_op)
            indirect_write_op: begin
              seq_next.state      = st_store;
              seq_next.dmem_we    = 1'b1;
              seq_next.dmem_wdata = source_gpr;
              seq_next.dmem_addr  = sel_ptr;
              if (issue_adj == adj_pre_dec) begin
                seq_next.dmem_addr = PTR_W'(sel_ptr - 1'b1);
              end
            end
            offset_write_op: begin
              // pointer plus displacement
              // the first pair takes no displacement; dropped
              if (issue_ptr != ptr_x) begin
                seq_next.state      = st_store;
                seq_next.dmem_we    = 1'b1;
                seq_next.dmem_addr  = PTR_W'(sel_ptr + {{(PTR_W-DISP_W){1'b0}}, issue_disp});
                seq_next.dmem_wdata = source_gpr;
              end
            end
            direct_write_op: begin
              seq_next.state      = st_store;
              seq_next.dmem_we    = 1'b1;
              seq_next.dmem_addr  = issue_direct_addr;
              seq_next.dmem_wdata = source_gpr;
            end
            code_fetch_op: begin
              // word address and byte lane from third pair
              seq_next.state        = st_fetch;
              seq_next.pmem_rd_en   = 1'b1;
              seq_next.pmem_addr    = ptr_z_value[PTR_W-1:1];
              seq_next.pmem_hi_byte = ptr_z_value[0];
              seq_next.gpr_widx     = issue_use_low_word ? LOW_WORD_GPR_IDX : issue_gpr_idx;
            end
            code_write_op: begin
              seq_next.state      = st_code_write;
              seq_next.pmem_we    = 1'b1;
              seq_next.pmem_addr  = ptr_z_value[PTR_W-1:1];
              seq_next.pmem_wdata = {high_word_gpr, low_word_gpr};
            end
            stack_save_op: begin
              seq_next.state       = st_stack;
              seq_next.stack_push  = 1'b1;
              seq_next.stack_wdata = source_gpr;
            end
            stack_restore_op: begin
              seq_next.state     = st_stack;
              seq_next.gpr_we    = 1'b1;
              seq_next.gpr_widx  = issue_gpr_idx;
              seq_next.gpr_wdata = stack_rdata;
            end
            doze_op: begin
              seq_next.sleep_req = 1'b1;
            end
            watchdog_kick_op: begin
              seq_next.watchdog_restart = 1'b1;
            end
            debug_halt_op: begin
              seq_next.state      = st_halted;
              seq_next.debug_halt = 1'b1;
            end
            default: seq_next.state = st_idle;
          endcase
        end
      end
      st_store: begin
        // store's second cycle; write strobe stands
        seq_next.state = st_idle;
      end
      st_fetch: begin
        // code memory answers while its read strobe stands
        seq_next.state     = st_fetch_wb;
        seq_next.gpr_we    = 1'b1;
        seq_next.gpr_wdata = seq_reg.pmem_hi_byte ? pmem_rdata[15:8] : pmem_rdata[7:0];
      end
      st_fetch_wb: begin
        // third cycle: register write stands
        seq_next.state = st_idle;
      end
      st_code_write: begin
        // unspecified length; two cycles like a store
        seq_next.state = st_idle;
      end
      st_stack: begin
        seq_next.state = st_idle;
      end
      st_halted: begin
        // halt is a pulse; the state holds off issue
        if (debug_resume) begin
          seq_next.state = st_idle;
        end
      end
      default: seq_next.state = st_idle;
    endcase
  end

  // single state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      seq_reg <= '{state: st_idle, default: '0};
    end else begin
      seq_reg <= seq_next;
    end
  end

  // outputs straight from the state register
  assign dmem_we          = seq_reg.dmem_we;
  assign dmem_addr        = seq_reg.dmem_addr;
  assign dmem_wdata       = seq_reg.dmem_wdata;
  assign pmem_rd_en       = seq_reg.pmem_rd_en;
  assign pmem_we          = seq_reg.pmem_we;
  assign pmem_addr        = seq_reg.pmem_addr;
  assign pmem_wdata       = seq_reg.pmem_wdata;
  assign stack_push       = seq_reg.stack_push;
  assign stack_wdata      = seq_reg.stack_wdata;
  assign gpr_we           = seq_reg.gpr_we;
  assign gpr_widx         = seq_reg.gpr_widx;
  assign gpr_wdata        = seq_reg.gpr_wdata;
  assign flags_we         = seq_reg.flags_we;
  assign sleep_req        = seq_reg.sleep_req;
  assign watchdog_restart = seq_reg.watchdog_restart;
  assign debug_halt       = seq_reg.debug_halt;

endmodule : move_ctrl_seq

/* tb/move_ctrl_checker.sv */
// concurrent checks on the move/control sequencer ports
// assumes it is bound onto move_ctrl_seq: one clock, async active-high reset
`timescale 1ns/1ps
module move_ctrl_checker
  import move_ctrl_pkg::*;
(
  // clock and reset
  input wire logic                     clock,
  input wire logic                     reset,
  // issue side
  input wire logic                     issue_valid,
  input wire logic                     issue_ready,
  input wire move_ctrl_pkg::op_t       issue_op,
  input wire move_ctrl_pkg::ptr_sel_t  issue_ptr,
  input wire move_ctrl_pkg::adj_t      issue_adj,
  input wire logic [15:0]              issue_direct_addr,
  input wire logic [7:0]               source_gpr,
  input wire logic [15:0]              ptr_x_value,
  // memory, stack and control outputs
  input wire logic                     dmem_we,
  input wire logic [15:0]              dmem_addr,
  input wire logic [7:0]               dmem_wdata,
  input wire logic                     pmem_rd_en,
  input wire logic                     pmem_we,
  input wire logic                     gpr_we,
  input wire logic                     stack_push,
  input wire logic [7:0]               stack_wdata,
  input wire logic                     stack_pop,
  input wire logic                     flags_we,
  input wire logic                     sleep_req,
  input wire logic                     watchdog_restart,
  input wire logic                     debug_halt
);
  logic take;
  logic store_go;
  logic x_step;

  // accepted work; offset via first pair is a no-op
  assign take = issue_valid && issue_ready;
  assign store_go = take && (issue_op == indirect_write_op || issue_op == direct_write_op ||
                             (issue_op == offset_write_op && issue_ptr != ptr_x));
  assign x_step = take && issue_op == indirect_write_op && issue_ptr == ptr_x;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_store_window: assert property (store_go |=> dmem_we && !issue_ready ##1 issue_ready)
    else $error("store window");
  chk_direct_target: assert property (take && issue_op == direct_write_op |=>
    dmem_addr == $past(issue_direct_addr) && dmem_wdata == $past(source_gpr))
    else $error("direct store");
  chk_post_step: assert property (x_step && issue_adj == adj_post_inc |=>
    dmem_addr == $past(ptr_x_value) && ptr_x_value == $past(ptr_x_value) + 16'h0001)
    else $error("post-inc store");
  chk_pre_step: assert property (x_step && issue_adj == adj_pre_dec |=>
    dmem_addr == $past(ptr_x_value) - 16'h0001 && ptr_x_value == dmem_addr)
    else $error("pre-dec store");
  chk_fetch_walk: assert property (take && issue_op == code_fetch_op |=>
    pmem_rd_en && !issue_ready ##1 gpr_we && !issue_ready ##1 issue_ready)
    else $error("fetch timing");
  chk_code_write: assert property (take && issue_op == code_write_op |=> pmem_we)
    else $error("code write");
  chk_save_push: assert property (take && issue_op == stack_save_op |=>
    stack_push && stack_wdata == $past(source_gpr) ##1 issue_ready)
    else $error("stack save wrong");
  chk_restore_pop: assert property (stack_pop == (take && issue_op == stack_restore_op))
    else $error("stack pop");
  chk_restore_write: assert property (take && issue_op == stack_restore_op |=> gpr_we)
    else $error("restore write");
  chk_doze_pulse: assert property (take && issue_op == doze_op |=> sleep_req && issue_ready)
    else $error("doze pulse wrong");
  chk_kick_pulse: assert property (take && issue_op == watchdog_kick_op |=> watchdog_restart)
    else $error("watchdog kick");
  chk_halt_pulse: assert property (take && issue_op == debug_halt_op |=> debug_halt && !issue_ready)
    else $error("debug halt wrong");
  chk_flags_quiet: assert property (!flags_we)
    else $error("flags written");
endmodule : move_ctrl_checker

bind move_ctrl_seq move_ctrl_checker move_ctrl_checker_i (.*);

/* tb/mem_partner.sv */
// behavioural data memory, code memory and stack behind the sequencer
// assumes one-cycle strobes and same-cycle reads
`timescale 1ns/1ps
module mem_partner
  import move_ctrl_pkg::*;
(
  // clock
  input wire logic                                   clock,
  // data memory write port
  input wire logic                                   dmem_we,
  input wire logic [move_ctrl_pkg::PTR_W-1:0]        dmem_addr,
  input wire logic [move_ctrl_pkg::DATA_W-1:0]       dmem_wdata,
  // code memory port
  input wire logic                                   pmem_rd_en,
  input wire logic                                   pmem_we,
  input wire logic [move_ctrl_pkg::CODE_ADDR_W-1:0]  pmem_addr,
  input wire logic [move_ctrl_pkg::CODE_DATA_W-1:0]  pmem_wdata,
  output logic [move_ctrl_pkg::CODE_DATA_W-1:0]      pmem_rdata,
  // stack port
  input wire logic                                   stack_push,
  input wire logic [move_ctrl_pkg::DATA_W-1:0]       stack_wdata,
  input wire logic                                   stack_pop,
  output logic [move_ctrl_pkg::DATA_W-1:0]           stack_rdata
);
  logic [7:0]  dmem [0:65535];
  logic [15:0] pmem [0:32767];
  logic [7:0]  stk [0:255];
  logic [7:0]  sp = 8'h00;

  // code words preset from their own address
  initial begin
    for (int i = 0; i < 32768; i++) begin
      pmem[i] = {8'(i) ^ 8'ha5, 8'(i)};
    end
  end

  // writes land on the edge that sees the strobe
  always @(posedge clock) begin
    if (dmem_we) dmem[dmem_addr] <= dmem_wdata;
    if (pmem_we) pmem[pmem_addr] <= pmem_wdata;
    if (stack_push) stk[sp] <= stack_wdata;
    sp <= sp + 8'(stack_push) - 8'(stack_pop);
  end

  // reads are only good while asked for; inverted otherwise so stale use shows
  assign pmem_rdata  = pmem_rd_en ? pmem[pmem_addr] : ~pmem[pmem_addr];
  assign stack_rdata = stack_pop ? stk[sp - 8'h01] : ~stk[sp - 8'h01];
endmodule : mem_partner

/* tb/move_ctrl_seq_test.sv */
// self-checking bench for the move/control sequencer
// assumes mem_partner on the memory side and the bound checker
`timescale 1ns/1ps
module move_ctrl_seq_test;
  import move_ctrl_pkg::*;
  logic             clock, reset, issue_valid, issue_ready, issue_use_low_word, ptr_load_en, debug_resume;
  op_t              issue_op;
  ptr_sel_t         issue_ptr, ptr_load_sel;
  adj_t             issue_adj;
  logic [5:0]       issue_disp;
  logic [15:0]      issue_direct_addr, ptr_load_value, ptr_x_value, ptr_y_value, ptr_z_value, dmem_addr;
  logic [4:0]       issue_gpr_idx, gpr_widx;
  logic [7:0]       source_gpr, low_word_gpr, high_word_gpr, dmem_wdata, stack_wdata, stack_rdata, gpr_wdata;
  logic [14:0]      pmem_addr;
  logic [15:0]      pmem_wdata, pmem_rdata;
  logic             dmem_we, pmem_rd_en, pmem_we, stack_push, stack_pop, gpr_we, flags_we;
  logic             sleep_req, watchdog_restart, debug_halt;
  int               n_fail, compares, cycles;

  move_ctrl_seq move_ctrl_seq_i (.*);
  mem_partner mem_partner_i (.*);

  // clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // hang guard, far past the run length
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_fail = n_fail + 1;
      results();
    end
  end

  task automatic results;
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick

  // one request, held for one clock edge only, accepted or not
  task automatic issue(input op_t op, input ptr_sel_t p = ptr_x, input adj_t a = adj_none,
                       input logic [15:0] k = 16'h0000, input logic [7:0] s = 8'h00);
    issue_valid = 1'b1;
    issue_op = op;
    issue_ptr = p;
    issue_adj = a;
    issue_direct_addr = k;
    source_gpr = s;
    tick();
    issue_valid = 1'b0;
  endtask : issue

  task automatic load_ptr(input ptr_sel_t p, input logic [15:0] v);
    ptr_load_en = 1'b1;
    ptr_load_sel = p;
    ptr_load_value = v;
    tick();
    ptr_load_en = 1'b0;
  endtask : load_ptr

  function automatic logic [15:0] ptr_of(input ptr_sel_t p);
    return (p == ptr_x) ? ptr_x_value : ((p == ptr_y) ? ptr_y_value : ptr_z_value);
  endfunction : ptr_of

  task automatic t_reset;
    chk("ptr_x", 16'h0000, ptr_x_value);
    chk("ptr_z", 16'h0000, ptr_z_value);
    chk("ready", 16'h0001, 16'(issue_ready));
  endtask : t_reset

  // every pair and adjust, on a carry/borrow boundary
  task automatic t_indirect;
    logic [7:0] d;
    for (int p = 0; p < 3; p++) begin
      for (int a = 0; a < 3; a++) begin
        d = 8'h10 + 8'(p * 3 + a);
        load_ptr(ptr_sel_t'(p), (a == 2) ? 16'h0100 : 16'h00ff);
        issue(indirect_write_op, ptr_sel_t'(p), adj_t'(a), 16'h0000, d);
        chk("dmem_we", 16'h0001, 16'(dmem_we));
        chk("dmem_addr", 16'h00ff, dmem_addr);
        chk("busy", 16'h0000, 16'(issue_ready));
        tick();
        chk("pointer", (a == 1) ? 16'h0100 : 16'h00ff, ptr_of(ptr_sel_t'(p)));
        chk("stored", 16'(d), 16'(mem_partner_i.dmem[16'h00ff]));
        chk("ready", 16'h0001, 16'(issue_ready));
      end
    end
  endtask : t_indirect

  task automatic t_offset_direct;
    issue_disp = 6'h3f;
    for (int p = 1; p < 3; p++) begin
      load_ptr(ptr_sel_t'(p), 16'hfff0);
      issue(offset_write_op, ptr_sel_t'(p), adj_none, 16'h0000, 8'h5a);
      chk("offset addr", 16'h002f, dmem_addr);
      chk("offset we", 16'h0001, 16'(dmem_we));
      tick();
      chk("offset ptr", 16'hfff0, ptr_of(ptr_sel_t'(p)));
    end
    issue(offset_write_op, ptr_x, adj_none, 16'h0000, 8'h5a);
    chk("offset x we", 16'h0000, 16'(dmem_we));
    tick();
    issue(direct_write_op, ptr_x, adj_none, 16'h1234, 8'hc7);
    chk("direct addr", 16'h1234, dmem_addr);
    chk("direct data", 16'h00c7, 16'(dmem_wdata));
    tick();
  endtask : t_offset_direct

  task automatic fetch(input adj_t a, input logic [4:0] idx, input logic [7:0] exp);
    issue(code_fetch_op, ptr_z, a);
    chk("rd_en", 16'h0001, 16'(pmem_rd_en));
    chk("fetch busy", 16'h0000, 16'(issue_ready));
    tick();
    chk("fetch idx", 16'(idx), 16'(gpr_widx));
    chk("fetch byte", 16'(exp), 16'(gpr_wdata));
    tick();
    chk("fetch ready", 16'h0001, 16'(issue_ready));
  endtask : fetch

  // write a word, read both bytes back
  task automatic t_code;
    load_ptr(ptr_z, 16'h0041);
    low_word_gpr = 8'h34;
    high_word_gpr = 8'h12;
    issue(code_write_op, ptr_z);
    chk("pmem_we", 16'h0001, 16'(pmem_we));
    chk("pmem_addr", 16'h0020, 16'(pmem_addr));
    chk("pmem_wdata", 16'h1234, pmem_wdata);
    tick();
    issue_use_low_word = 1'b1;
    issue_gpr_idx = 5'h11;
    fetch(adj_none, 5'h00, 8'h12);
    issue_use_low_word = 1'b0;
    load_ptr(ptr_z, 16'h0040);
    fetch(adj_post_inc, 5'h11, 8'h34);
    chk("fetch ptr", 16'h0041, ptr_z_value);
  endtask : t_code

  task automatic t_stack;
    logic [7:0] d [2];
    d = '{8'h3c, 8'hc3};
    issue_gpr_idx = 5'h07;
    for (int i = 0; i < 2; i++) begin
      issue(stack_save_op, ptr_x, adj_none, 16'h0000, d[i]);
      chk("push", 16'h0001, 16'(stack_push));
      chk("push data", 16'(d[i]), 16'(stack_wdata));
      tick();
    end
    for (int i = 0; i < 2; i++) begin
      issue(stack_restore_op);
      chk("restore we", 16'h0001, 16'(gpr_we));
      chk("restore idx", 16'h0007, 16'(gpr_widx));
      chk("restore data", 16'(d[1 - i]), 16'(gpr_wdata));
      tick();
    end
  endtask : t_stack

  // doze, kick back to back, halt, resume
  task automatic t_control;
    issue_valid = 1'b1;
    issue_op = doze_op;
    tick();
    chk("sleep_req", 16'h0001, 16'(sleep_req));
    chk("doze ready", 16'h0001, 16'(issue_ready));
    issue_op = watchdog_kick_op;
    tick();
    issue_valid = 1'b0;
    chk("kick", 16'h0001, 16'(watchdog_restart));
    chk("kick sleep", 16'h0000, 16'(sleep_req));
    issue(debug_halt_op);
    chk("halt", 16'h0001, 16'(debug_halt));
    tick();
    tick();
    chk("halted", 16'h0000, 16'(issue_ready));
    debug_resume = 1'b1;
    tick();
    debug_resume = 1'b0;
    chk("resumed", 16'h0001, 16'(issue_ready));
  endtask : t_control

  // main sequence
  initial begin
    n_fail = 0;
    compares = 0;
    cycles = 0;
    reset = 1'b1;
    issue_valid = 1'b0;
    issue_op = op_none;
    issue_use_low_word = 1'b0;
    ptr_load_en = 1'b0;
    debug_resume = 1'b0;
    repeat (2) @(posedge clock);
    #1 reset = 1'b0;
    t_reset();
    t_indirect();
    t_offset_direct();
    t_code();
    t_stack();
    t_control();
    results();
  end
endmodule : move_ctrl_seq_test
